// >>> design/mbrs_regs.svh
// constants, offsets and field positions of the memory bank read sequencer
`ifndef MBRS_REGS_SVH
`define MBRS_REGS_SVH
`define MBRS_ADDR_W 6
`define MBRS_OFF_CTRL 6'h00
`define MBRS_OFF_STATUS 6'h04
`define MBRS_OFF_START 6'h08
`define MBRS_OFF_LOWER0 6'h10
`define MBRS_OFF_UPPER0 6'h30
`define MBRS_OFF_END 8'h50
`define MBRS_LOWER_FIRST_LSB 12
`define MBRS_LOWER_INTER_LSB 4
`define MBRS_UPPER_REPEAT_BIT 14
`define MBRS_UPPER_ACK_LSB 8
`define MBRS_UPPER_TA_LSB 0
`define MBRS_LOWER_RESET 16'hffff
`define MBRS_UPPER_RESET 16'h7f01
`define MBRS_ACK_NONE 6'h3f
`define MBRS_ACK_LEAD 5'h03
`endif

// >>> design/mbrs_pkg.sv
// types of the memory bank read sequencer
package mbrs_pkg;
  typedef enum logic [2:0] {
    mbrs_idle,
    mbrs_start,
    mbrs_sample,
    mbrs_pc_end,
    mbrs_turn
  } mbrs_state_e;
  typedef struct packed {
    logic addr_latch_strobe;
    logic burst_frame;
    logic read_strobe;
    logic [7:0] bank_select;
    logic even_read_enable;
    logic odd_read_enable;
    logic datum_ready;
    logic internal_ack;
  } mbrs_pins_s;
endpackage

// >>> design/mbrs_seq.sv
// memory bank read sequencer with axi4-lite timing registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "mbrs_regs.svh"
module mbrs_seq
  import mbrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // axi4-lite slave
  input wire logic [`MBRS_ADDR_W+1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [`MBRS_ADDR_W+1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // memory side
  input wire logic external_wait,
  output mbrs_pins_s pins
);
  logic [1:0] rst_sync;
  logic rst_n;
  assign rst_n = rst_sync[1];
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // per-bank timing, 8 banks each
  logic [15:0] bank_timing_lower [8];
  logic [15:0] bank_timing_upper [8];
  logic [2:0] req_bank;
  logic [4:0] req_count;
  logic req_pcmcia;
  logic [1:0] req_bytes;
  logic go;
  logic busy;
  logic [15:0] done_count;
  mbrs_state_e state;

  // write path: address and data taken in either order
  logic aw_held, w_held;
  logic [`MBRS_ADDR_W+1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  assign do_write = aw_held && w_held && !s_bvalid;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= 2'b00;
    end
    else
    begin
      s_awready <= !aw_held && !s_awready && !s_bvalid;
      s_wready <= !w_held && !s_wready && !s_bvalid;
      if (s_awvalid && s_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_wdata;
        w_strb <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok(aw_addr) ? 2'b00 : 2'b10;
      end
      else if (s_bvalid && s_bready)
        s_bvalid <= 1'b0;
    end
  end

  function automatic logic wr_ok(input logic [`MBRS_ADDR_W+1:0] a);
    wr_ok = (a == {2'b00, `MBRS_OFF_CTRL}) || (a == {2'b00, `MBRS_OFF_START})
      || (a >= {2'b00, `MBRS_OFF_LOWER0} && a < `MBRS_OFF_END);
  endfunction

  // bank index of a timing register relative to its table base
  function automatic logic [2:0] bank_of(input logic [`MBRS_ADDR_W+1:0] a,
    input logic [`MBRS_ADDR_W+1:0] base);
    logic [`MBRS_ADDR_W+1:0] d;
    d = a - base;
    bank_of = d[4:2];
  endfunction

  // register storage; bank settings are per bank select
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
      begin
        bank_timing_lower[i] <= `MBRS_LOWER_RESET;
        bank_timing_upper[i] <= `MBRS_UPPER_RESET;
      end
      req_bank <= 3'h0;
      req_count <= 5'h01;
      req_pcmcia <= 1'b0;
      req_bytes <= 2'h3;
    end
    else if (do_write && w_strb[0] && wr_ok(aw_addr))
    begin
      if (aw_addr == {2'b00, `MBRS_OFF_CTRL})
      begin
        req_bank <= w_data[2:0];
        req_pcmcia <= w_data[3];
        req_bytes <= w_data[5:4];
        // zero length would stall; zero or more than 16 datums becomes 16
        req_count <= (w_data[12:8] == 5'h00 || w_data[12:8] > 5'h10) ? 5'h10 : w_data[12:8];
      end
      else if (aw_addr >= {2'b00, `MBRS_OFF_UPPER0})
        bank_timing_upper[bank_of(aw_addr, {2'b00, `MBRS_OFF_UPPER0})] <= w_data[15:0] & 16'h7f07;
      else if (aw_addr >= {2'b00, `MBRS_OFF_LOWER0})
        bank_timing_lower[bank_of(aw_addr, {2'b00, `MBRS_OFF_LOWER0})] <= w_data[15:0];
    end
  end

  // start command: writing the start offset launches one read, held while busy until the current read ends; held into pcmcia end it stays set, relaunching
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      go <= 1'b0;
    else if (do_write && aw_addr == {2'b00, `MBRS_OFF_START})
      go <= 1'b1;
    else if (state == mbrs_idle || state == mbrs_turn || state == mbrs_pc_end)
      go <= go && busy;
  end

  // read path
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= 2'b00;
    end
    else
    begin
      s_arready <= !s_rvalid && !s_arready;
      if (s_arvalid && s_arready)
      begin
        s_arready <= 1'b0;
        s_rvalid <= 1'b1;
        s_rresp <= 2'b00;
        s_rdata <= rd_word(s_araddr);
      end
      else if (s_rvalid && s_rready)
        s_rvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] rd_word(input logic [`MBRS_ADDR_W+1:0] a);
    logic [`MBRS_ADDR_W+1:0] o;
    o = a;
    rd_word = 32'h0;
    // nothing above the tables aliases back into them
    if (o >= `MBRS_OFF_END)
      rd_word = 32'h0;
    else if (o == {2'b00, `MBRS_OFF_CTRL})
      rd_word = {19'h0, req_count, 2'h0, req_bytes, req_pcmcia, req_bank};
    else if (o == {2'b00, `MBRS_OFF_STATUS})
      rd_word = {done_count, 15'h0, busy};
    else if (o >= {2'b00, `MBRS_OFF_UPPER0})
      rd_word = {16'h0, bank_timing_upper[bank_of(o, {2'b00, `MBRS_OFF_UPPER0})]};
    else if (o >= {2'b00, `MBRS_OFF_LOWER0})
      rd_word = {16'h0, bank_timing_lower[bank_of(o, {2'b00, `MBRS_OFF_LOWER0})]};
  endfunction

  // external wait: three-stage capture, change accepted when stages 2 and 3 agree
  logic [2:0] wait_sync;
  logic wait_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_sync <= 3'h0;
      wait_q <= 1'b0;
    end
    else
    begin
      wait_sync <= {wait_sync[1:0], external_wait};
      if (wait_sync[2] == wait_sync[1])
        wait_q <= wait_sync[2];
    end
  end

  // transaction state
  logic [2:0] bank;
  logic pcm;
  logic [1:0] pbytes;
  logic rep_left;
  logic [3:0] wcnt;
  logic [4:0] left;
  logic [5:0] ack_cnt;
  logic ack_done;
  logic [2:0] ta_cnt;
  logic sampled;
  logic [3:0] first_d, inter_d;
  logic [5:0] ack_d;
  logic [2:0] ta_d;
  logic rep_d;
  logic wait_now, dr_next, last_next, odd_en;
  assign first_d = bank_timing_lower[bank][`MBRS_LOWER_FIRST_LSB +: 4];
  // interleaved banks are not built; every bank runs non-interleaved
  assign inter_d = bank_timing_lower[bank][`MBRS_LOWER_INTER_LSB +: 4];
  assign ack_d = bank_timing_upper[bank][`MBRS_UPPER_ACK_LSB +: 6];
  assign ta_d = bank_timing_upper[bank][`MBRS_UPPER_TA_LSB +: 3];
  assign rep_d = bank_timing_upper[bank][`MBRS_UPPER_REPEAT_BIT];
  assign busy = state != mbrs_idle;
  assign sampled = state == mbrs_sample && pins.datum_ready;
  // pcmcia odd-byte-only reads use the odd lane
  assign odd_en = pcm ? pbytes == 2'b10 : bank[0];

  function automatic logic [7:0] pair_sel(input logic [2:0] b, input logic [1:0] by);
    pair_sel = 8'h0;
    pair_sel[{b[2:1], 1'b0}] = by[0];
    pair_sel[{b[2:1], 1'b1}] = by[1];
  endfunction

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= mbrs_idle;
      bank <= 3'h0;
      pcm <= 1'b0;
      pbytes <= 2'h0;
      rep_left <= 1'b0;
      wcnt <= 4'h0;
      left <= 5'h0;
      ack_cnt <= 6'h0;
      ack_done <= 1'b0;
      ta_cnt <= 3'h0;
      done_count <= 16'h0;
    end
    else
    begin
      case (state)
        mbrs_idle, mbrs_pc_end:
        begin
          if (go)
          begin
            state <= mbrs_start;
            bank <= req_bank;
            pcm <= req_pcmcia;
            pbytes <= req_bytes;
            left <= req_count;
            rep_left <= bank_timing_upper[req_bank][`MBRS_UPPER_REPEAT_BIT];
            ack_cnt <= 6'h0;
            ack_done <= 1'b0;
          end
          else
            state <= mbrs_idle;
        end
        mbrs_start:
        begin
          ack_cnt <= ack_cnt + 6'h1;
          if (rep_left)
            rep_left <= 1'b0;
          else
          begin
            state <= mbrs_sample;
            wcnt <= first_d;
          end
        end
        mbrs_sample:
        begin
          ack_cnt <= ack_cnt + 6'h1;
          if (wcnt != 4'h0)
            wcnt <= wcnt - 4'h1;
          else if (sampled)
          begin
            left <= left - 5'h1;
            wcnt <= inter_d;
            if (left == 5'h1)
            begin
              done_count <= done_count + 16'h1;
              ta_cnt <= (ta_d == 3'h0) ? 3'h1 : ta_d;
              state <= pcm ? mbrs_pc_end : mbrs_turn;
            end
          end
          if (ack_d != `MBRS_ACK_NONE && ack_cnt == ack_d)
            ack_done <= 1'b1;
        end
        mbrs_turn:
        begin
          ta_cnt <= ta_cnt - 3'h1;
          if (ta_cnt == 3'h1)
            state <= mbrs_idle;
        end
        default:
          state <= mbrs_idle;
      endcase
    end
  end

  // registered pin outputs
  mbrs_pins_s next_pins;
  always_comb
  begin
    wait_now = (wait_sync[2] == wait_sync[1]) ? wait_sync[2] : wait_q;
    last_next = left == (sampled ? 5'h2 : 5'h1);
    dr_next = 1'b0;
    if (state == mbrs_start && !rep_left)
      dr_next = first_d == 4'h0;
    else if (state == mbrs_sample)
      dr_next = (wcnt != 4'h0) ? wcnt == 4'h1 : (!sampled || (left > 5'h1 && inter_d == 4'h0));
    // decided a cycle early since the pin is registered
    dr_next = dr_next && !wait_now;
    next_pins = pins;
    next_pins.addr_latch_strobe = 1'b0;
    next_pins.datum_ready = 1'b0;
    next_pins.internal_ack = 1'b0;
    next_pins.even_read_enable = 1'b0;
    next_pins.odd_read_enable = 1'b0;
    if (state == mbrs_idle && go)
    begin
      next_pins.addr_latch_strobe = 1'b1;
      next_pins.burst_frame = 1'b1;
      next_pins.read_strobe = 1'b1;
      next_pins.bank_select = req_pcmcia ? 8'h0 : (8'h1 << req_bank);
    end
    else if (state == mbrs_start && !rep_left)
    begin
      if (pcm)
      begin
        next_pins.burst_frame = 1'b0;
        next_pins.bank_select = pair_sel(bank, pbytes);
      end
      next_pins.even_read_enable = !odd_en;
      next_pins.odd_read_enable = odd_en;
    end
    else if (state == mbrs_sample)
    begin
      next_pins.even_read_enable = !odd_en && !sampled;
      next_pins.odd_read_enable = odd_en && !sampled;
      if (sampled && left == 5'h2)
        next_pins.burst_frame = 1'b0;
      if (sampled && left > 5'h1)
      begin
        next_pins.even_read_enable = !odd_en;
        next_pins.odd_read_enable = odd_en;
      end
      if (sampled && left == 5'h1)
      begin
        if (pcm)
          next_pins.bank_select = 8'h0;
        // strobe held, select too unless pcmcia; next start may reuse them
        next_pins.read_strobe = 1'b1;
      end
      if (ack_d != `MBRS_ACK_NONE && ack_cnt == ack_d && !ack_done && left > 5'h1)
        next_pins.internal_ack = 1'b1;
    end
    if (state == mbrs_start && !rep_left && left == 5'h1 && !pcm)
      next_pins.burst_frame = 1'b0;
    if (state == mbrs_turn && ta_cnt == 3'h1)
    begin
      next_pins.read_strobe = 1'b0;
      next_pins.bank_select = 8'h0;
    end
    next_pins.datum_ready = dr_next;
    if (dr_next && last_next && !ack_done && !next_pins.internal_ack)
      next_pins.internal_ack = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pins <= '0;
    else
      pins <= next_pins;
  end
endmodule

// >>> sim/mbrs_chk.sv
// assertions on the read sequencer memory-side ports
`timescale 1ns/1ps
module mbrs_chk
  import mbrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // memory side
  input wire logic external_wait,
  input wire mbrs_pins_s pins
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_last;
    pins.datum_ready && !pins.burst_frame;
  endsequence
  // five held cycles cover the capture stages and the registered pin
  sequence s_stall;
    external_wait [*5];
  endsequence
  property p_frame; pins.addr_latch_strobe |-> pins.burst_frame; endproperty
  property p_rd; pins.addr_latch_strobe |-> pins.read_strobe; endproperty
  property p_nodr; pins.addr_latch_strobe |-> !pins.datum_ready; endproperty
  property p_odd; pins.odd_read_enable |-> |(pins.bank_select & 8'haa); endproperty
  property p_even; pins.even_read_enable |-> |(pins.bank_select & 8'h55); endproperty
  property p_excl; !(pins.even_read_enable && pins.odd_read_enable); endproperty
  property p_drrd; pins.datum_ready |-> pins.read_strobe; endproperty
  property p_drcs; pins.datum_ready |-> pins.bank_select != 8'h00; endproperty
  property p_stall; s_stall |-> !pins.datum_ready; endproperty
  property p_turn;
    s_last |=> !(pins.even_read_enable || pins.odd_read_enable);
  endproperty
  a_frame: assert property (p_frame) else $error("start without frame");
  a_rd: assert property (p_rd) else $error("start without read strobe");
  a_nodr: assert property (p_nodr) else $error("datum ready in start cycle");
  a_odd: assert property (p_odd) else $error("odd enable on even bank");
  a_even: assert property (p_even) else $error("even enable on odd bank");
  a_excl: assert property (p_excl) else $error("both read enables high");
  a_drrd: assert property (p_drrd) else $error("datum ready outside read");
  a_drcs: assert property (p_drcs) else $error("datum ready with no bank");
  a_stall: assert property (p_stall) else $error("datum sampled under wait");
  a_turn: assert property (p_turn) else $error("no idle after last datum");
endmodule
bind mbrs_seq mbrs_chk u_chk (
  .clock(clock),
  .nrst(nrst),
  .external_wait(external_wait),
  .pins(pins)
);

// >>> sim/mbrs_mem.sv
// far-side memory bank model that can stall with its wait line
`timescale 1ns/1ps
module mbrs_mem
  import mbrs_pkg::*;
(
  // clock
  input wire logic clock,
  // memory side
  input wire mbrs_pins_s pins,
  input wire logic [3:0] hold,
  output logic external_wait
);
  logic [3:0] left = 4'h0;
  // dual-port style: busy for hold cycles from each start, prompt when zero
  always @(posedge clock)
  begin
    if (pins.addr_latch_strobe)
      left <= hold;
    else if (left != 4'h0)
      left <= left - 4'h1;
  end
  assign external_wait = (left != 4'h0);
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the memory bank read sequencer
`timescale 1ns/1ps
`include "mbrs_regs.svh"
module tb_top
  import mbrs_pkg::*;
;
  logic clock, nrst, aw_v, w_v, ar_v, aw_r, w_r, b_v, ar_r, r_v, ext_wait;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d;
  logic [1:0] b_resp, r_resp;
  logic [3:0] hold;
  mbrs_pins_s pins;
  int miscompares, n_compared, cyc, off, n_dr, last_dr, ack_off, n_ack, idle, gap;
  logic [7:0] cs_or;
  logic bf1, en_bad, cur_odd, cur_pc;
  logic [31:0] d;
  mbrs_seq DUT (.clock(clock), .nrst(nrst), .s_awaddr(aw_a), .s_awvalid(aw_v),
    .s_awready(aw_r), .s_wdata(w_d), .s_wstrb(4'hf), .s_wvalid(w_v), .s_wready(w_r),
    .s_bresp(b_resp), .s_bvalid(b_v), .s_bready(1'b1), .s_araddr(ar_a), .s_arvalid(ar_v),
    .s_arready(ar_r), .s_rdata(r_d), .s_rresp(r_resp), .s_rvalid(r_v), .s_rready(1'b1),
    .external_wait(ext_wait), .pins(pins));
  mbrs_mem u_mem (.clock(clock), .pins(pins), .hold(hold), .external_wait(ext_wait));
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // settled outputs are sampled mid-cycle; offsets count from the start cycle
  always @(negedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miscompares++;
      print_verdict();
    end
    off++;
    if (pins.addr_latch_strobe)
    begin
      off = 0;
      cs_or = 8'h00;
      n_ack = 0;
      en_bad = 1'b0;
    end
    cs_or |= pins.bank_select;
    if (off == 1)
      bf1 = pins.burst_frame;
    if (pins.datum_ready)
    begin
      n_dr++;
      last_dr = off;
      if (!cur_pc && !(cur_odd ? pins.odd_read_enable : pins.even_read_enable))
        en_bad = 1'b1;
    end
    if (pins.internal_ack)
    begin
      n_ack++;
      ack_off = off;
    end
    if (pins.even_read_enable || pins.odd_read_enable)
    begin
      if (idle > 0)
        gap = idle;
      idle = 0;
    end
    else
      idle++;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    aw_a <= a;
    w_d <= dat;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    while (pa || pw)
    begin
      @(negedge clock);
      ta = pa && aw_r;
      tw = pw && w_r;
      @(posedge clock);
      if (ta) aw_v <= 1'b0;
      if (tw) w_v <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do
    begin
      @(negedge clock);
      ta = b_v;
      tw = (b_resp === er);
      @(posedge clock);
    end while (!ta);
    check("bresp", 1, tw);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    logic t;
    ar_a <= a;
    ar_v <= 1'b1;
    do
    begin
      @(negedge clock);
      t = ar_r;
      @(posedge clock);
    end while (!t);
    ar_v <= 1'b0;
    do
    begin
      @(negedge clock);
      t = r_v;
      dat = r_d;
      @(posedge clock);
    end while (!t);
  endtask
  task automatic idle_wait();
    int k;
    k = 0;
    do
    begin
      rd({2'b00, `MBRS_OFF_STATUS}, d);
      k++;
    end while (d[0] !== 1'b0 && k < 200);
    check("busy", 0, d[0]);
  endtask
  // case: bank, datums, first, inter, repeat, ack, pcmcia and byte lanes
  task automatic run(input logic [35:0] c, input logic [2:0] ta, input logic stall);
    logic [3:0] b;
    logic [4:0] n;
    int el;
    b = c[35:32];
    n = c[28:24];
    el = 1 + c[15:12] + c[23:20] + (c[19:16] + 1) * (n - 1);
    cur_odd = b[0];
    cur_pc = c[3];
    wr({2'b00, `MBRS_OFF_LOWER0} + {2'b00, b, 2'b00}, {16'h0, c[23:20], 4'h0, c[19:16], 4'h0}, 0);
    wr({2'b00, `MBRS_OFF_UPPER0} + {2'b00, b, 2'b00},
      {17'h0, c[12], c[9:4], 5'h00, ta}, 0);
    wr({2'b00, `MBRS_OFF_CTRL}, {19'h0, 1'b0, n[3:0], 2'b00, c[1:0], c[3], b[2:0]}, 0);
    n_dr = 0;
    wr({2'b00, `MBRS_OFF_START}, 32'h1, 0);
    idle_wait();
    check("datums", n, n_dr);
    if (stall)
      check("stalled", 1, last_dr > el);
    else
      check("length", el, last_dr);
    check("selects", c[3] ? {6'h0, c[1:0]} << {b[2:1], 1'b0} : 8'h1 << b, cs_or);
    check("acks", 1, n_ack);
    if (c[11:4] == 8'h3f)
      check("ack at last", last_dr, ack_off);
    else
      check("ack early", 1, ack_off < last_dr);
    check("frame", c[3] ? 0 : (n > 1 || c[12]), bf1);
    check("enable", 0, en_bad);
    $display("test done %0h", c);
  endtask
  logic [35:0] cases [10] = '{36'h0_01_000_3f_0, 36'h3_01_001_3f_0, 36'h4_01_f00_3f_0,
    36'h5_04_120_3f_0, 36'h2_10_000_3f_0, 36'h6_08_110_0c_0, 36'h1_04_0f1_3f_0,
    36'h2_01_000_3f_b, 36'h4_01_200_3f_9, 36'h6_01_000_3f_a};
  initial
  begin
    nrst = 1'b0;
    {aw_v, w_v, ar_v} = 3'b000;
    {aw_a, ar_a, w_d, hold} = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i += 7)
    begin
      rd({2'b00, `MBRS_OFF_LOWER0} + 8'(4 * i), d);
      check("lower reset", `MBRS_LOWER_RESET, d);
      rd({2'b00, `MBRS_OFF_UPPER0} + 8'(4 * i), d);
      check("upper reset", `MBRS_UPPER_RESET, d);
    end
    rd(8'hfc, d);
    check("unmapped", 0, d);
    wr(8'hfc, 32'h5, 2'b10);
    foreach (cases[i])
      run(cases[i], 3'h1, 1'b0);
    hold <= 4'h6;
    run(36'h0_01_400_3f_0, 3'h1, 1'b1);
    hold <= 4'h0;
    run(36'h0_01_000_3f_0, 3'h3, 1'b0);
    gap = 0;
    wr({2'b00, `MBRS_OFF_START}, 32'h1, 0);
    wr({2'b00, `MBRS_OFF_START}, 32'h1, 0);
    idle_wait();
    check("turnaround", 1, gap >= 3);
    print_verdict();
  end
endmodule
